// ### rtl/port_power_ctrl.sv
// power state sequencer for one usb port power switch
// Summary of operation
// [RQ1] core supply low forces off: state discarded, all switches open
// [RQ2] sleep keeps logic alive, serial wake only, every switch open
// [RQ3] detect watches for attach, high-speed off, no current monitoring
// [RQ4] a present fault moves the controller into error
// [RQ5] active closes port power, enables emulation, limiting and rationing
// [RQ6] sleep chosen for enable off with select 0, or all modes zero; the code picks detect for all modes zero with select 1
// [RQ7] detect chosen with select 1 and enable off or source low
// [RQ8] detect with everything valid waits for attach then goes active itself
// [RQ9] select 0 with valid supply, enable and mode gives permanent active
// [RQ10] select 1 with attached device gives active with removal detection
// [RQ11] host changes mode before dropping enable to leave pass-through
// [RQ12] select 0, cycling mode, nothing attached: profiles cycle
// [RQ13] current limit fixed at power-up, later only lowered
// [RQ14] host uses only documented pin combinations
// [RQ15] detect to active: attach off, bypass off, discharge, then power
// [RQ16] leaving error only after every fault condition has gone
// [RQ17] all pin and comparator inputs synchronised before use
// [RQ18] off resets the machine; state re-chosen when core supply returns
`default_nettype none
module port_power_ctrl #(
	parameter int DISCHARGE_TIME_US = 200,
	parameter int RECOVERY_TIME_US = 100000,
	parameter int TIMER_W = 24,
	parameter int LIMIT_W = 4
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic core_supply_ok,
	input wire logic source_above_uvlo,
	input wire logic port_power_enable_input,
	input wire logic attach_detect_select,
	input wire logic mode_select_first,
	input wire logic mode_select_second,
	input wire logic emulation_enable_input,
	input wire logic attach_detected,
	input wire logic removal_detected,
	input wire logic fault_present,
	input wire logic fault_latch_mode,
	input wire logic [LIMIT_W-1:0] limit_strap,
	input wire logic fault_clear,
	input wire logic limit_write,
	input wire logic [LIMIT_W-1:0] limit_request,
	output pwr_pkg::power_state_t state,
	output logic port_power_switch,
	output logic bypass_switch,
	output logic discharge_switch,
	output logic hs_switch,
	output logic vbus_pulldown,
	output logic attach_detect_enable,
	output logic removal_detect_enable,
	output logic emulation_active,
	output logic current_monitor_enable,
	output logic profile_cycling,
	output logic serial_enable,
	output logic serial_full_access,
	output logic fault_alert,
	output logic [LIMIT_W-1:0] overcurrent_limit
);
	localparam int NIN = pwr_pkg::IN_STRAP + LIMIT_W;
	localparam int DIS_CYCLES = (DISCHARGE_TIME_US * pwr_pkg::NS_PER_US
		+ pwr_pkg::CLK_PERIOD_NS - 1) / pwr_pkg::CLK_PERIOD_NS;
	localparam int REC_CYCLES = (RECOVERY_TIME_US * pwr_pkg::NS_PER_US
		+ pwr_pkg::CLK_PERIOD_NS - 1) / pwr_pkg::CLK_PERIOD_NS;

	logic [NIN-1:0] pins;
	logic [NIN-1:0] s;
	tmr_if #(.W(TIMER_W)) tmr();

	assign pins = {limit_strap, fault_latch_mode, fault_present, removal_detected,
		attach_detected, emulation_enable_input, mode_select_second, mode_select_first,
		attach_detect_select, port_power_enable_input, source_above_uvlo, core_supply_ok};

	// nothing below looks at a raw pin [RQ17]
	sync_bank #(.W(NIN)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.d(pins),
		.q(s)
	);

	wait_timer #(.W(TIMER_W)) u_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.t(tmr)
	);

	logic core_ok;
	logic src_ok;
	logic pe;
	logic s0;
	logic fault;
	logic [2:0] mode;
	logic any_mode;
	logic attached;
	logic pe_prev;
	pwr_pkg::power_state_t desired;
	pwr_pkg::power_state_t next_state;
	logic next_attached;
	logic next_pe_prev;
	logic [LIMIT_W-1:0] next_limit;
	logic release_err;

	assign core_ok = s[pwr_pkg::IN_CORE];
	assign src_ok = s[pwr_pkg::IN_SRC];
	assign pe = s[pwr_pkg::IN_PE];
	assign s0 = s[pwr_pkg::IN_S0];
	assign fault = s[pwr_pkg::IN_FAULT];
	assign mode = {s[pwr_pkg::IN_EM], s[pwr_pkg::IN_M2], s[pwr_pkg::IN_M1]};
	assign any_mode = mode != pwr_pkg::MODE_ALL_ZERO;

	// state that the pins ask for
	always_comb begin
		if (!s0) begin
			if (pe && src_ok && any_mode) begin
				desired = pwr_pkg::st_active; // [RQ9]
			end else if (!pe && mode == pwr_pkg::MODE_PASS_THROUGH
				&& state == pwr_pkg::st_active) begin
				// pass-through holds until the mode pins move first [RQ11]
				desired = pwr_pkg::st_active;
			end else begin
				desired = pwr_pkg::st_sleep; // [RQ6]
			end
		end else if (pe && src_ok && any_mode && attached) begin
			desired = pwr_pkg::st_active; // [RQ10]
		end else begin
			desired = pwr_pkg::st_detect; // [RQ7] [RQ8]
		end
	end

	always_comb begin
		next_state = state;
		next_attached = attached;
		next_pe_prev = pe;
		next_limit = overcurrent_limit;
		tmr.load = 1'b0;
		tmr.count = TIMER_W'(REC_CYCLES);
		// latch choice read only through its synchroniser [RQ17]
		if (s[pwr_pkg::IN_LATCH]) begin
			release_err = fault_clear || pe != pe_prev;
		end else begin
			release_err = tmr.done;
		end
		if (s[pwr_pkg::IN_REMOVAL] && removal_detect_enable) begin
			next_attached = 1'b0;
			release_err = 1'b1;
		end
		// attach sets over a removal in the same cycle
		if (s[pwr_pkg::IN_ATTACH] && attach_detect_enable) begin
			next_attached = 1'b1;
		end
		if (state != pwr_pkg::st_off && limit_write && limit_request < overcurrent_limit) begin
			next_limit = limit_request; // [RQ13]
		end
		case (state)
			pwr_pkg::st_off: begin
				next_limit = s[pwr_pkg::IN_STRAP +: LIMIT_W]; // [RQ13]
				next_state = desired; // [RQ18]
			end
			pwr_pkg::st_sleep, pwr_pkg::st_active: begin
				next_state = desired;
			end
			pwr_pkg::st_detect: begin
				if (desired == pwr_pkg::st_active) begin
					next_state = pwr_pkg::st_discharge; // [RQ15]
					tmr.load = 1'b1;
					tmr.count = TIMER_W'(DIS_CYCLES);
				end else begin
					next_state = desired;
				end
			end
			pwr_pkg::st_discharge: begin
				if (desired != pwr_pkg::st_active) begin
					next_state = desired;
				end else if (tmr.done) begin
					next_state = pwr_pkg::st_active; // [RQ15]
				end
			end
			pwr_pkg::st_error: begin
				if (release_err) begin
					if (!fault) begin
						next_state = desired; // [RQ16]
					end else if (!s[pwr_pkg::IN_LATCH]) begin
						tmr.load = 1'b1; // retry after another wait
					end
				end
			end
			default: begin
				next_state = pwr_pkg::st_off;
			end
		endcase
		if (fault && state != pwr_pkg::st_off && state != pwr_pkg::st_error) begin
			next_state = pwr_pkg::st_error; // [RQ4]
			tmr.load = !s[pwr_pkg::IN_LATCH];
			tmr.count = TIMER_W'(REC_CYCLES);
		end
		if (!core_ok) begin
			next_state = pwr_pkg::st_off; // [RQ1] [RQ18]
			next_attached = 1'b0;
			next_limit = '0;
		end
	end

	logic next_pps;
	logic next_byp;
	logic next_dis;
	logic next_hs;
	logic next_pd;
	logic next_att_en;
	logic next_rem_en;
	logic next_emu;
	logic next_mon;
	logic next_cyc;
	logic next_ser;
	logic next_ser_full;
	logic next_alert;

	// outputs follow the next state so they change on the same edge
	always_comb begin
		next_pps = next_state == pwr_pkg::st_active; // [RQ5]
		next_byp = next_state == pwr_pkg::st_detect;
		next_dis = next_state == pwr_pkg::st_discharge; // [RQ15]
		next_hs = next_state == pwr_pkg::st_active && pwr_pkg::HS_MODE_MASK[mode]; // [RQ3]
		next_pd = next_state == pwr_pkg::st_sleep; // [RQ2]
		next_att_en = next_state == pwr_pkg::st_detect; // [RQ3]
		next_rem_en = (s0 && (next_state == pwr_pkg::st_active
			|| next_state == pwr_pkg::st_discharge)) || next_state == pwr_pkg::st_error;
		next_emu = next_state == pwr_pkg::st_active; // [RQ5]
		next_mon = next_state == pwr_pkg::st_active;
		next_cyc = next_state == pwr_pkg::st_active && !s0 && !next_attached
			&& mode == pwr_pkg::MODE_PROFILE_CYCLE; // [RQ12]
		next_ser = next_state != pwr_pkg::st_off; // [RQ1] [RQ2]
		next_ser_full = next_ser && next_state != pwr_pkg::st_sleep;
		next_alert = next_state == pwr_pkg::st_error;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= pwr_pkg::st_off;
			attached <= 1'b0;
			pe_prev <= 1'b0;
			overcurrent_limit <= '0;
			port_power_switch <= 1'b0;
			bypass_switch <= 1'b0;
			discharge_switch <= 1'b0;
			hs_switch <= 1'b0;
			vbus_pulldown <= 1'b0;
			attach_detect_enable <= 1'b0;
			removal_detect_enable <= 1'b0;
			emulation_active <= 1'b0;
			current_monitor_enable <= 1'b0;
			profile_cycling <= 1'b0;
			serial_enable <= 1'b0;
			serial_full_access <= 1'b0;
			fault_alert <= 1'b0;
		end else begin
			state <= next_state;
			attached <= next_attached;
			pe_prev <= next_pe_prev;
			overcurrent_limit <= next_limit;
			port_power_switch <= next_pps;
			bypass_switch <= next_byp;
			discharge_switch <= next_dis;
			hs_switch <= next_hs;
			vbus_pulldown <= next_pd;
			attach_detect_enable <= next_att_en;
			removal_detect_enable <= next_rem_en;
			emulation_active <= next_emu;
			current_monitor_enable <= next_mon;
			profile_cycling <= next_cyc;
			serial_enable <= next_ser;
			serial_full_access <= next_ser_full;
			fault_alert <= next_alert;
		end
	end

	// helper: cycles spent in the discharge step
	logic [TIMER_W-1:0] dis_cnt;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dis_cnt <= '0;
		end else begin
			dis_cnt <= (state == pwr_pkg::st_discharge) ? dis_cnt + TIMER_W'(1) : '0;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	property p_off_open;
		!core_ok |=> state == pwr_pkg::st_off && !port_power_switch && !bypass_switch
			&& !hs_switch && !serial_enable && !attached;
	endproperty
	a_off_open: assert property (p_off_open) else $error("off with a switch closed"); // [RQ1]

	property p_sleep_open;
		state == pwr_pkg::st_sleep |-> !port_power_switch && !bypass_switch && !hs_switch
			&& vbus_pulldown && serial_enable && !serial_full_access;
	endproperty
	a_sleep_open: assert property (p_sleep_open) else $error("sleep outputs wrong"); // [RQ2]

	property p_detect_watch;
		state == pwr_pkg::st_detect |-> attach_detect_enable && !hs_switch
			&& !port_power_switch && !current_monitor_enable && serial_full_access;
	endproperty
	a_detect_watch: assert property (p_detect_watch) else $error("detect outputs wrong"); // [RQ3]

	property p_fault_error;
		fault && core_ok && state != pwr_pkg::st_off |=> state == pwr_pkg::st_error
			&& fault_alert && !port_power_switch;
	endproperty
	a_fault_error: assert property (p_fault_error) else $error("fault missed"); // [RQ4]

	property p_active_full;
		state == pwr_pkg::st_active |-> port_power_switch && emulation_active
			&& current_monitor_enable && !bypass_switch;
	endproperty
	a_active_full: assert property (p_active_full) else $error("active not full"); // [RQ5]

	property p_sleep_pick;
		core_ok && !fault && !s0 && pe && !any_mode && state != pwr_pkg::st_error
			|=> state == pwr_pkg::st_sleep;
	endproperty
	a_sleep_pick: assert property (p_sleep_pick) else $error("sleep not chosen"); // [RQ6]

	property p_detect_pick;
		core_ok && !fault && s0 && !pe && state inside {pwr_pkg::st_sleep, pwr_pkg::st_active}
			|=> state == pwr_pkg::st_detect;
	endproperty
	a_detect_pick: assert property (p_detect_pick) else $error("detect not chosen"); // [RQ7]

	property p_active_pick;
		core_ok && !fault && !s0 && pe && src_ok && any_mode
			&& state inside {pwr_pkg::st_sleep, pwr_pkg::st_active}
			|=> state == pwr_pkg::st_active && !attach_detect_enable && !removal_detect_enable;
	endproperty
	a_active_pick: assert property (p_active_pick) else $error("active not chosen"); // [RQ9]

	sequence s_enter_discharge;
		state == pwr_pkg::st_detect ##1 state == pwr_pkg::st_discharge;
	endsequence
	sequence s_discharge_outputs;
		discharge_switch && !bypass_switch && !attach_detect_enable && !port_power_switch;
	endsequence
	property p_discharge_order;
		s_enter_discharge |-> s_discharge_outputs;
	endproperty
	a_discharge_order: assert property (p_discharge_order) else $error("bad discharge"); // [RQ15]

	property p_discharge_len;
		state == pwr_pkg::st_active && $past(state) == pwr_pkg::st_discharge
			|-> $past(dis_cnt) == TIMER_W'(DIS_CYCLES) && !discharge_switch;
	endproperty
	a_discharge_len: assert property (p_discharge_len) else $error("discharge length"); // [RQ15]

	property p_limit_down;
		state != pwr_pkg::st_off && $past(state) != pwr_pkg::st_off
			|-> overcurrent_limit <= $past(overcurrent_limit);
	endproperty
	a_limit_down: assert property (p_limit_down) else $error("current limit raised"); // [RQ13]

	property p_error_exit;
		$past(state) == pwr_pkg::st_error && state != pwr_pkg::st_error
			&& state != pwr_pkg::st_off |-> !$past(fault);
	endproperty
	a_error_exit: assert property (p_error_exit) else $error("left error with fault"); // [RQ16]
endmodule
`default_nettype wire

// ### rtl/pwr_pkg.sv
// shared constants and types for the port power state controller
`default_nettype none
package pwr_pkg;
	typedef enum logic [2:0] {
		st_off,
		st_sleep,
		st_detect,
		st_discharge,
		st_active,
		st_error
	} power_state_t;
	localparam int CLK_PERIOD_NS = 100;
	localparam int NS_PER_US = 1000;
	localparam int SYNC_STAGES = 2;
	// mode code is {emulation_enable_input, mode_select_second, mode_select_first}
	localparam logic [2:0] MODE_ALL_ZERO = 3'h0;
	localparam logic [2:0] MODE_PASS_THROUGH = 3'h1;
	localparam logic [2:0] MODE_PROFILE_CYCLE = 3'h7;
	// one bit per mode code: high-speed switch closed in active
	localparam logic [7:0] HS_MODE_MASK = 8'h0e;
	// bit positions in the synchronised pin vector
	localparam int IN_CORE = 0;
	localparam int IN_SRC = 1;
	localparam int IN_PE = 2;
	localparam int IN_S0 = 3;
	localparam int IN_M1 = 4;
	localparam int IN_M2 = 5;
	localparam int IN_EM = 6;
	localparam int IN_ATTACH = 7;
	localparam int IN_REMOVAL = 8;
	localparam int IN_FAULT = 9;
	localparam int IN_LATCH = 10;
	localparam int IN_STRAP = 11;
endpackage
`default_nettype wire

// ### rtl/tmr_if.sv
// load and done signals between the sequencer and its wait timer
`default_nettype none
interface tmr_if #(parameter int W = 24);
	logic load;
	logic [W-1:0] count;
	logic done;
	modport ctrl(output load, output count, input done);
	modport cnt(input load, input count, output done);
endinterface
`default_nettype wire

// ### rtl/sync_bank.sv
// two-stage synchronisers for a vector of pin inputs
`default_nettype none
module sync_bank #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta;
			logic next_meta;
			logic next_q;
			always_comb begin
				next_meta = d[i];
				next_q = meta;
			end
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					meta <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta <= next_meta;
					q[i] <= next_q;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### rtl/wait_timer.sv
// down counter that pulses done when a loaded wait runs out
`default_nettype none
module wait_timer #(
	parameter int W = 24
) (
	input wire logic mclk,
	input wire logic reset_n,
	tmr_if.cnt t
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_done;
	always_comb begin
		next_cnt = cnt;
		if (t.load) begin
			next_cnt = t.count;
		end else if (cnt != '0) begin
			next_cnt = cnt - W'(1);
		end
		next_done = !t.load && (cnt == W'(1));
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
			t.done <= 1'b0;
		end else begin
			cnt <= next_cnt;
			t.done <= next_done;
		end
	end
endmodule
`default_nettype wire

// ### verif/host_pin_model.sv
// host controller and port-side pin model for the port power controller
`default_nettype none
module host_pin_model (
	input wire logic mclk,
	output logic core_supply_ok,
	output logic source_above_uvlo,
	output logic port_power_enable_input,
	output logic attach_detect_select,
	output logic mode_select_first,
	output logic mode_select_second,
	output logic emulation_enable_input,
	output logic attach_detected,
	output logic removal_detected,
	output logic fault_present,
	output logic fault_latch_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{core_supply_ok, source_above_uvlo, port_power_enable_input} = 3'h0;
		{attach_detect_select, mode_select_first, mode_select_second} = 3'h0;
		{emulation_enable_input, attach_detected, removal_detected} = 3'h0;
		{fault_present, fault_latch_mode} = 2'h0;
	end
	// only table combinations are ever driven here
	task automatic set_ctrl(input logic src, input logic pe, input logic sel,
			input logic [2:0] mode);
		@(negedge mclk);
		source_above_uvlo = src;
		port_power_enable_input = pe;
		attach_detect_select = sel;
		{emulation_enable_input, mode_select_second, mode_select_first} = mode;
	endtask
	task automatic set_port(input logic core, input logic att, input logic rem,
			input logic flt, input logic latch);
		@(negedge mclk);
		core_supply_ok = core;
		attach_detected = att;
		removal_detected = rem;
		fault_present = flt;
		fault_latch_mode = latch;
	endtask
	// mode first, enable later, or pass-through would hold active
	task automatic leave_pass_through();
		@(negedge mclk);
		{emulation_enable_input, mode_select_second, mode_select_first} = 3'h0;
		repeat (4) @(negedge mclk);
		port_power_enable_input = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verif/port_power_ctrl_tb.sv
// self-checking bench for the port power state controller
`default_nettype none
module port_power_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIS_CYCLES = 10;
	logic mclk;
	logic reset_n;
	logic fault_clear;
	logic limit_write;
	logic [3:0] limit_request;
	logic [3:0] strap;
	logic core, src, pe, sel, m1, m2, em, att, rem, flt, latch;
	pwr_pkg::power_state_t state;
	logic pps, byp, dis, hs, pd, ade, rde, emu, mon, cyc, ser, sfa, alert;
	logic [3:0] limit;
	int errors;
	int check_count;
	int n;
	wire logic [7:0] sw = {pps, byp, dis, hs, pd, ade, rde, alert};
	wire logic [7:0] misc = {3'h0, cyc, emu, mon, ser, sfa};

	host_pin_model host (.mclk(mclk), .core_supply_ok(core), .source_above_uvlo(src),
		.port_power_enable_input(pe), .attach_detect_select(sel),
		.mode_select_first(m1), .mode_select_second(m2), .emulation_enable_input(em),
		.attach_detected(att), .removal_detected(rem), .fault_present(flt),
		.fault_latch_mode(latch));

	// short waits keep the run brief: 10 discharge and 20 recovery cycles
	port_power_ctrl #(.DISCHARGE_TIME_US(1), .RECOVERY_TIME_US(2)) dut (
		.mclk(mclk), .reset_n(reset_n), .core_supply_ok(core), .source_above_uvlo(src),
		.port_power_enable_input(pe), .attach_detect_select(sel),
		.mode_select_first(m1), .mode_select_second(m2), .emulation_enable_input(em),
		.attach_detected(att), .removal_detected(rem), .fault_present(flt),
		.fault_latch_mode(latch), .limit_strap(strap), .fault_clear(fault_clear),
		.limit_write(limit_write), .limit_request(limit_request), .state(state),
		.port_power_switch(pps), .bypass_switch(byp), .discharge_switch(dis),
		.hs_switch(hs), .vbus_pulldown(pd), .attach_detect_enable(ade),
		.removal_detect_enable(rde), .emulation_active(emu),
		.current_monitor_enable(mon), .profile_cycling(cyc), .serial_enable(ser),
		.serial_full_access(sfa), .fault_alert(alert), .overcurrent_limit(limit));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// bounded wait; running out counts as a mismatch and closes the run
	task automatic wait_state(input pwr_pkg::power_state_t s, input int bound);
		int k;
		k = 0;
		while (state !== s && k < bound) begin
			@(negedge mclk);
			k++;
		end
		if (state !== s) begin
			errors++;
			$display("MISMATCH at %0t: state wait ran out", $time);
			report_and_stop();
		end
	endtask

	task automatic write_limit(input logic [3:0] v);
		@(negedge mclk);
		limit_write = 1'b1;
		limit_request = v;
		@(negedge mclk);
		limit_write = 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	initial begin
		errors = 0;
		check_count = 0;
		reset_n = 1'b0;
		fault_clear = 1'b0;
		limit_write = 1'b0;
		limit_request = 4'h0;
		strap = 4'h9;
		repeat (16) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_off));
		check(sw, 8'h00);
		reset_n = 1'b1;
		repeat (6) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_off));
		$display("test off_at_reset done");

		host.set_port(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_state(pwr_pkg::st_sleep, 20);
		check(sw, 8'h08);
		check(misc, 8'h02);
		check(8'(limit), 8'h09);
		host.set_ctrl(1'b1, 1'b1, 1'b0, 3'h0);
		repeat (6) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_sleep));
		$display("test sleep done");

		host.set_ctrl(1'b1, 1'b0, 1'b1, 3'h2);
		wait_state(pwr_pkg::st_detect, 20);
		check(sw, 8'h44);
		check(misc, 8'h03);
		host.set_ctrl(1'b0, 1'b1, 1'b1, 3'h2);
		repeat (6) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_detect));
		host.set_ctrl(1'b1, 1'b1, 1'b1, 3'h2);
		repeat (10) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_detect));
		$display("test detect done");

		host.set_port(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		wait_state(pwr_pkg::st_discharge, 20);
		check(sw, 8'h22);
		n = 0;
		while (state === pwr_pkg::st_discharge && n < 50) begin
			@(negedge mclk);
			n++;
		end
		check(8'(n), 8'(DIS_CYCLES + 1));
		check(8'(state), 8'(pwr_pkg::st_active));
		check(sw, 8'h92);
		check(misc, 8'h0f);
		host.set_port(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test auto_attach done");

		// a raise is refused, a lower value is kept
		write_limit(4'hc);
		check(8'(limit), 8'h09);
		write_limit(4'h5);
		check(8'(limit), 8'h05);
		$display("test limit done");

		host.set_port(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		wait_state(pwr_pkg::st_error, 20);
		check(sw & 8'hd1, 8'h01);
		repeat (40) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_error));
		host.set_port(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_state(pwr_pkg::st_active, 60);
		check(sw, 8'h92);
		$display("test auto_recovery done");

		host.set_port(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		wait_state(pwr_pkg::st_error, 20);
		host.set_port(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		repeat (40) @(negedge mclk);
		check(8'(state), 8'(pwr_pkg::st_error));
		fault_clear = 1'b1;
		@(negedge mclk);
		fault_clear = 1'b0;
		wait_state(pwr_pkg::st_active, 20);
		check(sw & 8'hd1, 8'h90);
		$display("test latched_fault done");

		// removal while select is 1 forgets the device, so cycling can start
		host.set_port(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		wait_state(pwr_pkg::st_detect, 20);
		check(sw, 8'h44);
		host.set_port(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		host.set_ctrl(1'b1, 1'b1, 1'b0, 3'h7);
		wait_state(pwr_pkg::st_active, 40);
		check(8'(state), 8'(pwr_pkg::st_active));
		check(sw, 8'h80);
		check(misc, 8'h1f);
		host.set_ctrl(1'b1, 1'b1, 1'b0, 3'h1);
		repeat (6) @(negedge mclk);
		check(sw, 8'h90);
		host.leave_pass_through();
		wait_state(pwr_pkg::st_sleep, 20);
		check(sw, 8'h08);
		$display("test pass_through done");

		host.set_port(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_state(pwr_pkg::st_off, 20);
		check(sw, 8'h00);
		check(misc, 8'h00);
		check(8'(limit), 8'h00);
		// a new strap value proves the limit is taken again on leaving off
		strap = 4'h6;
		host.set_port(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_state(pwr_pkg::st_sleep, 20);
		check(8'(limit), 8'h06);
		$display("test core_loss done");
		report_and_stop();
	end
endmodule
`default_nettype wire
